// file: logic/mcr_pkg.sv
package mcr_pkg;

  localparam int          ADDR_W   = 16;
  localparam int          DATA_W   = 32;
  localparam int          ACC_W    = 42;
  localparam int          PAD_W    = ACC_W - DATA_W;
  localparam int          NUM_REGS = 23;
  localparam int          IDX_W    = 5;

  // Register offsets
  localparam logic [15:0] OFS_CUR_DET_THR   = 16'h2002;
  localparam logic [15:0] OFS_NOISE_V_LO    = 16'h200B;
  localparam logic [15:0] OFS_NOISE_V_HI    = 16'h200C;
  localparam logic [15:0] OFS_NOISE_A_LO    = 16'h200D;
  localparam logic [15:0] OFS_NOISE_A_HI    = 16'h200E;
  localparam logic [15:0] OFS_NOISE_B_LO    = 16'h2010;
  localparam logic [15:0] OFS_NOISE_B_HI    = 16'h2011;
  localparam logic [15:0] OFS_DC_V          = 16'h2018;
  localparam logic [15:0] OFS_DC_A          = 16'h2020;
  localparam logic [15:0] OFS_DC_B          = 16'h2028;
  localparam logic [15:0] OFS_P1_GAIN       = 16'h20E8;
  localparam logic [15:0] OFS_P2_GAIN       = 16'h20E9;
  localparam logic [15:0] OFS_V_RMS_GAIN    = 16'h20EA;
  localparam logic [15:0] OFS_I1_RMS_GAIN   = 16'h20EB;
  localparam logic [15:0] OFS_I2_RMS_GAIN   = 16'h20EC;
  localparam logic [15:0] OFS_P1_OFFSET     = 16'h20ED;
  localparam logic [15:0] OFS_P2_OFFSET     = 16'h20EE;
  localparam logic [15:0] OFS_BPF_COEF      = 16'h20EF;
  localparam logic [15:0] OFS_P1_PULSE_THR  = 16'h20F4;
  localparam logic [15:0] OFS_P1_NOLOAD_THR = 16'h20F5;
  localparam logic [15:0] OFS_P2_PULSE_THR  = 16'h20FA;
  localparam logic [15:0] OFS_P2_NOLOAD_THR = 16'h20FB;
  localparam logic [15:0] OFS_P1_CONST_PWR  = 16'h20FC;
  localparam logic [15:0] OFS_CREEP_STATUS  = 16'h287F;

  // Storage indices, in offset table order
  localparam logic [4:0]  IDX_BPF_COEF      = 5'h11;

  // Reset values, and the alternate coefficient BPF_COEF_SLOW
  localparam logic [31:0] RST_ZERO          = 32'h00000000;
  localparam logic [31:0] RST_BPF_COEF      = 32'h889374BC;
  localparam logic [31:0] BPF_COEF_SLOW     = 32'h911D3C9C;

  // Creep status fields
  localparam int          CREEP_P1_BIT      = 7;
  localparam int          CREEP_P2_BIT      = 6;

  // Timing
  localparam longint      CLK_HZ            = 100_000_000;
  localparam longint      TICK_FAST_HZ      = 12800;
  localparam longint      TICK_SLOW_HZ      = 2979;
  localparam int          TICK_FAST_CYC     = int'(CLK_HZ / TICK_FAST_HZ);
  localparam int          TICK_SLOW_CYC     = int'(CLK_HZ / TICK_SLOW_HZ);

  typedef struct packed {
    logic signed [31:0] p1_active;
    logic signed [31:0] p2_reactive;
    logic signed [31:0] p2_active;
  } mcr_power_t;

  typedef struct packed {
    logic [31:0] cur_det_thr;
    logic [31:0] noise_v_lo;
    logic [31:0] noise_v_hi;
    logic [31:0] noise_a_lo;
    logic [31:0] noise_a_hi;
    logic [31:0] noise_b_lo;
    logic [31:0] noise_b_hi;
    logic [31:0] dc_v;
    logic [31:0] dc_a;
    logic [31:0] dc_b;
    logic [31:0] p1_gain;
    logic [31:0] p2_gain;
    logic [31:0] v_rms_gain;
    logic [31:0] i1_rms_gain;
    logic [31:0] i2_rms_gain;
    logic [31:0] p1_offset;
    logic [31:0] p2_offset;
    logic [31:0] bpf_coef;
    logic [31:0] p1_pulse_thr;
    logic [31:0] p1_noload_thr;
    logic [31:0] p2_pulse_thr;
    logic [31:0] p2_noload_thr;
    logic [31:0] p1_const_pwr;
  } mcr_cal_t;

  typedef struct packed {
    logic [41:0] p1_pulse;
    logic [41:0] p2_pulse;
    logic [41:0] p1_noload;
    logic [41:0] p2_noload;
  } mcr_thr42_t;

endpackage

// file: logic/mcr_top.sv
// Our own choice: strobed register access.
`timescale 1ns/10ps
`default_nettype none
module mcr_top
  import mcr_pkg::*;
#(
  parameter int FAST_TICK_CYC = TICK_FAST_CYC,
  parameter int SLOW_TICK_CYC = TICK_SLOW_CYC
) (
  input  wire logic              CLK_IN,
  input  wire logic              RST_IN,
  input  wire logic              CE_IN,
  input  wire logic [15:0]       ADDR_IN,
  input  wire logic [31:0]       WDATA_IN,
  input  wire logic              WR_IN,
  input  wire logic              RD_IN,
  output logic      [31:0]       RDATA_OUT,
  input  wire logic              NOLOAD_EN_IN,
  input  wire logic              SLOW_METER_CLK_IN,
  input  wire logic              CONST_POWER_SEL_IN,
  input  wire logic              DUAL_ACTIVE_SEL_IN,
  input  wire mcr_power_t        POWER_IN,
  output mcr_cal_t               CAL_OUT,
  output mcr_thr42_t             THR42_OUT,
  output logic                   CREEP_P1_OUT,
  output logic                   CREEP_P2_OUT,
  output logic                   ACC_TICK_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  function automatic logic [5:0] reg_index(input logic [15:0] a);
    logic [5:0] r;
    r = 6'h3F;
    case (a)
      OFS_CUR_DET_THR:   r = 6'h00;
      OFS_NOISE_V_LO:    r = 6'h01;
      OFS_NOISE_V_HI:    r = 6'h02;
      OFS_NOISE_A_LO:    r = 6'h03;
      OFS_NOISE_A_HI:    r = 6'h04;
      OFS_NOISE_B_LO:    r = 6'h05;
      OFS_NOISE_B_HI:    r = 6'h06;
      OFS_DC_V:          r = 6'h07;
      OFS_DC_A:          r = 6'h08;
      OFS_DC_B:          r = 6'h09;
      OFS_P1_GAIN:       r = 6'h0A;
      OFS_P2_GAIN:       r = 6'h0B;
      OFS_V_RMS_GAIN:    r = 6'h0C;
      OFS_I1_RMS_GAIN:   r = 6'h0D;
      OFS_I2_RMS_GAIN:   r = 6'h0E;
      OFS_P1_OFFSET:     r = 6'h0F;
      OFS_P2_OFFSET:     r = 6'h10;
      OFS_BPF_COEF:      r = {1'b0, IDX_BPF_COEF};
      OFS_P1_PULSE_THR:  r = 6'h12;
      OFS_P1_NOLOAD_THR: r = 6'h13;
      OFS_P2_PULSE_THR:  r = 6'h14;
      OFS_P2_NOLOAD_THR: r = 6'h15;
      OFS_P1_CONST_PWR:  r = 6'h16;
      default:           r = 6'h3F;
    endcase
    return r;
  endfunction

  // Threshold widened to accumulator width
  function automatic logic [ACC_W-1:0] pad42(input logic [31:0] t);
    return {t, {PAD_W{1'b0}}};
  endfunction

  // Magnitude of a signed power sample, zero extended
  function automatic logic [ACC_W-1:0] mag42(input logic signed [31:0] p);
    logic [31:0] m;
    m = p[31] ? 32'(-p) : 32'(p);
    return {{PAD_W{1'b0}}, m};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  logic [31:0] regs_r   [NUM_REGS];
  logic [31:0] regs_nxt [NUM_REGS];
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        creep1_r;
  logic        creep2_r;
  logic [5:0]  widx;
  logic [5:0]  ridx;

  assign widx = reg_index(ADDR_IN);
  assign ridx = widx;

  always_comb begin
    for (int i = 0; i < NUM_REGS; i++) begin
      regs_nxt[i] = regs_r[i];
    end
    // Whole word only; no byte lanes, so a partial update cannot be seen
    if (WR_IN && widx < 6'(NUM_REGS)) begin
      regs_nxt[widx[IDX_W-1:0]] = WDATA_IN;
    end
    rdata_nxt = RST_ZERO;
    if (RD_IN) begin
      if (ADDR_IN == OFS_CREEP_STATUS) begin
        rdata_nxt[CREEP_P1_BIT] = creep1_r;
        rdata_nxt[CREEP_P2_BIT] = creep2_r;
      end else if (ridx < 6'(NUM_REGS)) begin
        rdata_nxt = regs_r[ridx[IDX_W-1:0]];
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_r[i] <= RST_ZERO;
      end
      regs_r[IDX_BPF_COEF] <= RST_BPF_COEF;
      rdata_r              <= RST_ZERO;
    end else if (CE_IN) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_r[i] <= regs_nxt[i];
      end
      rdata_r <= rdata_nxt;
    end
  end

  assign RDATA_OUT = rdata_r;

  // Raw words go to the datapath, which applies the two's complement scaling
  assign CAL_OUT.cur_det_thr   = regs_r[0];
  assign CAL_OUT.noise_v_lo    = regs_r[1];
  assign CAL_OUT.noise_v_hi    = regs_r[2];
  assign CAL_OUT.noise_a_lo    = regs_r[3];
  assign CAL_OUT.noise_a_hi    = regs_r[4];
  assign CAL_OUT.noise_b_lo    = regs_r[5];
  assign CAL_OUT.noise_b_hi    = regs_r[6];
  assign CAL_OUT.dc_v          = regs_r[7];
  assign CAL_OUT.dc_a          = regs_r[8];
  assign CAL_OUT.dc_b          = regs_r[9];
  assign CAL_OUT.p1_gain       = regs_r[10];
  assign CAL_OUT.p2_gain       = regs_r[11];
  assign CAL_OUT.v_rms_gain    = regs_r[12];
  assign CAL_OUT.i1_rms_gain   = regs_r[13];
  assign CAL_OUT.i2_rms_gain   = regs_r[14];
  assign CAL_OUT.p1_offset     = regs_r[15];
  assign CAL_OUT.p2_offset     = regs_r[16];
  assign CAL_OUT.bpf_coef      = regs_r[17];
  assign CAL_OUT.p1_pulse_thr  = regs_r[18];
  assign CAL_OUT.p1_noload_thr = regs_r[19];
  assign CAL_OUT.p2_pulse_thr  = regs_r[20];
  assign CAL_OUT.p2_noload_thr = regs_r[21];
  assign CAL_OUT.p1_const_pwr  = regs_r[22];

  assign THR42_OUT.p1_pulse  = pad42(regs_r[18]);
  assign THR42_OUT.p2_pulse  = pad42(regs_r[20]);
  assign THR42_OUT.p1_noload = pad42(regs_r[19]);
  assign THR42_OUT.p2_noload = pad42(regs_r[21]);

  ////////////////////////////////////////////////////////////////////////////
  // Accumulation tick

  logic [31:0] tick_cnt_r;
  logic [31:0] tick_cnt_nxt;
  logic        tick_r;
  logic        tick_nxt;
  logic [31:0] tick_last;

  always_comb begin
    tick_last    = SLOW_METER_CLK_IN ? 32'(SLOW_TICK_CYC - 1)
                                     : 32'(FAST_TICK_CYC - 1);
    tick_nxt     = 1'b0;
    tick_cnt_nxt = tick_cnt_r + 32'h00000001;
    // Clamp also catches a rate switch that leaves the count past its end
    if (tick_cnt_r >= tick_last) begin
      tick_cnt_nxt = RST_ZERO;
      tick_nxt     = 1'b1;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      tick_cnt_r <= RST_ZERO;
      tick_r     <= 1'b0;
    end else if (CE_IN) begin
      tick_cnt_r <= tick_cnt_nxt;
      tick_r     <= tick_nxt;
    end
  end

  assign ACC_TICK_OUT = tick_r;

  ////////////////////////////////////////////////////////////////////////////
  // No-load race, one lane per path

  logic [ACC_W-1:0] e1_acc_r;
  logic [ACC_W-1:0] e1_acc_nxt;
  logic [ACC_W-1:0] e2_acc_r;
  logic [ACC_W-1:0] e2_acc_nxt;
  logic [31:0]      ac1_r;
  logic [31:0]      ac1_nxt;
  logic [31:0]      ac2_r;
  logic [31:0]      ac2_nxt;
  logic             creep1_nxt;
  logic             creep2_nxt;
  logic [ACC_W-1:0] e1_in;
  logic [ACC_W-1:0] e2_in;
  logic [ACC_W-1:0] e1_sum;
  logic [ACC_W-1:0] e2_sum;

  always_comb begin
    e1_in = CONST_POWER_SEL_IN ? mag42(regs_r[22]) : mag42(POWER_IN.p1_active);
    e2_in = DUAL_ACTIVE_SEL_IN ? mag42(POWER_IN.p2_active)
                               : mag42(POWER_IN.p2_reactive);
    e1_sum     = e1_acc_r + e1_in;
    e2_sum     = e2_acc_r + e2_in;
    e1_acc_nxt = e1_acc_r;
    e2_acc_nxt = e2_acc_r;
    ac1_nxt    = ac1_r;
    ac2_nxt    = ac2_r;
    creep1_nxt = creep1_r;
    creep2_nxt = creep2_r;
    if (!NOLOAD_EN_IN) begin
      // Race restarts cleanly once detection is re-armed
      e1_acc_nxt = '0;
      e2_acc_nxt = '0;
      ac1_nxt    = RST_ZERO;
      ac2_nxt    = RST_ZERO;
      creep1_nxt = 1'b0;
      creep2_nxt = 1'b0;
    end else if (tick_r) begin
      ac1_nxt    = ac1_r + 32'h00000001;
      ac2_nxt    = ac2_r + 32'h00000001;
      e1_acc_nxt = e1_sum;
      e2_acc_nxt = e2_sum;
      // Energy is checked first, so a tie goes to metering
      if (e1_sum >= pad42(regs_r[19])) begin
        e1_acc_nxt = e1_sum - pad42(regs_r[19]);
        ac1_nxt    = RST_ZERO;
        creep1_nxt = 1'b0;
      end else if (ac1_nxt >= regs_r[19]) begin
        e1_acc_nxt = '0;
        ac1_nxt    = RST_ZERO;
        creep1_nxt = 1'b1;
      end
      if (e2_sum >= pad42(regs_r[21])) begin
        e2_acc_nxt = e2_sum - pad42(regs_r[21]);
        ac2_nxt    = RST_ZERO;
        creep2_nxt = 1'b0;
      end else if (ac2_nxt >= regs_r[21]) begin
        e2_acc_nxt = '0;
        ac2_nxt    = RST_ZERO;
        creep2_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      e1_acc_r <= '0;
      e2_acc_r <= '0;
      ac1_r    <= RST_ZERO;
      ac2_r    <= RST_ZERO;
      creep1_r <= 1'b0;
      creep2_r <= 1'b0;
    end else if (CE_IN) begin
      e1_acc_r <= e1_acc_nxt;
      e2_acc_r <= e2_acc_nxt;
      ac1_r    <= ac1_nxt;
      ac2_r    <= ac2_nxt;
      creep1_r <= creep1_nxt;
      creep2_r <= creep2_nxt;
    end
  end

  assign CREEP_P1_OUT = creep1_r;
  assign CREEP_P2_OUT = creep2_r;

endmodule
`default_nettype wire

// file: dv/mcr_top_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module mcr_top_monitor
  import mcr_pkg::*;
#(
  parameter int FAST_TICK_CYC = TICK_FAST_CYC,
  parameter int SLOW_TICK_CYC = TICK_SLOW_CYC
) (
  input wire logic        CLK_IN,
  input wire logic        RST_IN,
  input wire logic        CE_IN,
  input wire logic [15:0] ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic        WR_IN,
  input wire logic        RD_IN,
  input wire logic [31:0] RDATA_OUT,
  input wire logic        NOLOAD_EN_IN,
  input wire logic        SLOW_METER_CLK_IN,
  input wire logic        CONST_POWER_SEL_IN,
  input wire logic        DUAL_ACTIVE_SEL_IN,
  input wire mcr_power_t  POWER_IN,
  input wire mcr_cal_t    CAL_OUT,
  input wire mcr_thr42_t  THR42_OUT,
  input wire logic        CREEP_P1_OUT,
  input wire logic        CREEP_P2_OUT,
  input wire logic        ACC_TICK_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  ////////////////////////////////////////
  // A rate change restarts the period count, the first period after it may be partial
  int   gap_r;
  logic seen_r;
  logic mode_r;
  logic tick_r;
  always_ff @(posedge CLK_IN) begin
    mode_r <= SLOW_METER_CLK_IN;
    tick_r <= ACC_TICK_OUT;
    if (RST_IN || mode_r != SLOW_METER_CLK_IN) begin
      gap_r  <= 0;
      seen_r <= 1'b0;
    end else if (ACC_TICK_OUT && !tick_r) begin
      gap_r  <= 0;
      seen_r <= 1'b1;
    end else if (CE_IN) begin
      gap_r <= gap_r + 1;
    end
  end
  ////////////////////////////////////////
  // A frozen cycle holds the last read data, so only an enabled idle cycle must clear it
  rd_idle_zero_a: assert property ($past(CE_IN) && !$past(RD_IN) |-> RDATA_OUT == 32'h00000000)
    else $error("read data not zero outside read");
  wr_cal_a: assert property (CE_IN && WR_IN && ADDR_IN == OFS_BPF_COEF
    |=> CAL_OUT.bpf_coef == $past(WDATA_IN)) else $error("coefficient write not applied");
  wr_rd_back_a: assert property (CE_IN && WR_IN && ADDR_IN == OFS_P1_GAIN ##1
    CE_IN && RD_IN && ADDR_IN == OFS_P1_GAIN |=> RDATA_OUT == $past(WDATA_IN, 2))
    else $error("back to back read lost write");
  thr_pad_a: assert property (THR42_OUT.p1_pulse == {CAL_OUT.p1_pulse_thr, 10'h000} &&
    THR42_OUT.p2_noload == {CAL_OUT.p2_noload_thr, 10'h000} &&
    THR42_OUT.p1_noload == {CAL_OUT.p1_noload_thr, 10'h000} &&
    THR42_OUT.p2_pulse == {CAL_OUT.p2_pulse_thr, 10'h000}) else $error("threshold padding");
  creep_read_a: assert property (CE_IN && RD_IN && ADDR_IN == OFS_CREEP_STATUS |=>
    RDATA_OUT == {24'h000000, $past(CREEP_P1_OUT), $past(CREEP_P2_OUT), 6'h00})
    else $error("creep status read wrong");
  unmapped_zero_a: assert property (CE_IN && RD_IN && ADDR_IN == 16'h2001 |=> RDATA_OUT == 32'h0)
    else $error("unmapped read not zero");
  noload_off_a: assert property (CE_IN && !NOLOAD_EN_IN |=> !CREEP_P1_OUT && !CREEP_P2_OUT)
    else $error("creep while detection off");
  creep_on_tick_a: assert property ($rose(CREEP_P1_OUT) || $rose(CREEP_P2_OUT) |->
    $past(ACC_TICK_OUT && NOLOAD_EN_IN)) else $error("creep set without tick");
  reset_dflt_a: assert property (disable iff (1'b0) RST_IN |=> CAL_OUT.bpf_coef == RST_BPF_COEF
    && CAL_OUT.p1_gain == RST_ZERO && !CREEP_P1_OUT && !ACC_TICK_OUT) else $error("reset value");
  tick_period_a: assert property (ACC_TICK_OUT && !tick_r && seen_r && mode_r == SLOW_METER_CLK_IN
    |-> gap_r == (SLOW_METER_CLK_IN ? SLOW_TICK_CYC : FAST_TICK_CYC) - 1) else $error("tick period");
  creep_c: cover property ($rose(CREEP_P1_OUT));
  clear_c: cover property ($fell(CREEP_P2_OUT));
  status_c: cover property (RD_IN && ADDR_IN == OFS_CREEP_STATUS && CREEP_P2_OUT);
endmodule
bind mcr_top mcr_top_monitor #(.FAST_TICK_CYC(FAST_TICK_CYC), .SLOW_TICK_CYC(SLOW_TICK_CYC)) u_mon (
  .CLK_IN(CLK_IN), .RST_IN(RST_IN), .CE_IN(CE_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN),
  .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT), .NOLOAD_EN_IN(NOLOAD_EN_IN),
  .SLOW_METER_CLK_IN(SLOW_METER_CLK_IN), .CONST_POWER_SEL_IN(CONST_POWER_SEL_IN),
  .DUAL_ACTIVE_SEL_IN(DUAL_ACTIVE_SEL_IN), .POWER_IN(POWER_IN), .CAL_OUT(CAL_OUT),
  .THR42_OUT(THR42_OUT), .CREEP_P1_OUT(CREEP_P1_OUT), .CREEP_P2_OUT(CREEP_P2_OUT),
  .ACC_TICK_OUT(ACC_TICK_OUT));
`default_nettype wire

// file: dv/mcr_top_bench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin \
  n_tests++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("mismatch at %0t: got %h expected %h", $time, (g), (e)); \
  end \
end
module mcr_top_bench
  import mcr_pkg::*;
;
  localparam int FT = 8;
  localparam int ST = 20;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        ce_in = 1'b1;
  logic [15:0] addr_in = 16'h0000;
  logic [31:0] wdata_in = 32'h0;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  logic        nl_en = 1'b0;
  logic        slow = 1'b0;
  logic        cpsel = 1'b0;
  logic        dsel = 1'b0;
  mcr_power_t  pwr = '0;
  logic [31:0] rdata;
  mcr_cal_t    cal;
  mcr_thr42_t  thr;
  logic        cr1;
  logic        cr2;
  logic        tick;
  int          fail_count = 0;
  int          n_tests = 0;
  int          tgap;
  logic [31:0] got;
  logic [31:0] exp_r [NUM_REGS];
  logic [15:0] ofs [NUM_REGS] = '{OFS_CUR_DET_THR, OFS_NOISE_V_LO, OFS_NOISE_V_HI, OFS_NOISE_A_LO,
    OFS_NOISE_A_HI, OFS_NOISE_B_LO, OFS_NOISE_B_HI, OFS_DC_V, OFS_DC_A, OFS_DC_B, OFS_P1_GAIN,
    OFS_P2_GAIN, OFS_V_RMS_GAIN, OFS_I1_RMS_GAIN, OFS_I2_RMS_GAIN, OFS_P1_OFFSET, OFS_P2_OFFSET,
    OFS_BPF_COEF, OFS_P1_PULSE_THR, OFS_P1_NOLOAD_THR, OFS_P2_PULSE_THR, OFS_P2_NOLOAD_THR,
    OFS_P1_CONST_PWR};
  always #5 clk_in = ~clk_in;
  mcr_top #(.FAST_TICK_CYC(FT), .SLOW_TICK_CYC(ST)) u_dut (
    .CLK_IN(clk_in), .RST_IN(rst_in), .CE_IN(ce_in), .ADDR_IN(addr_in), .WDATA_IN(wdata_in),
    .WR_IN(wr_in), .RD_IN(rd_in), .RDATA_OUT(rdata), .NOLOAD_EN_IN(nl_en),
    .SLOW_METER_CLK_IN(slow), .CONST_POWER_SEL_IN(cpsel), .DUAL_ACTIVE_SEL_IN(dsel),
    .POWER_IN(pwr), .CAL_OUT(cal), .THR42_OUT(thr), .CREEP_P1_OUT(cr1), .CREEP_P2_OUT(cr2),
    .ACC_TICK_OUT(tick));
  ////////////////////////////////////////
  function automatic logic [31:0] dflt(int i);
    return (i == IDX_BPF_COEF) ? RST_BPF_COEF : RST_ZERO;
  endfunction
  task automatic give_verdict();
    $display("counts: %0d compares, %0d mismatches", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 got = rdata;
  endtask
  task automatic chk_all();
    for (int i = 0; i < NUM_REGS; i++) begin
      rd(ofs[i]);
      `CHK(got, exp_r[i])
      `CHK(cal[DATA_W*(NUM_REGS-i)-1 -: DATA_W], exp_r[i])
    end
  endtask
  // Returns one edge after the tick, when the race decision is visible
  task automatic wait_tick(input int n);
    for (int j = 0; j < n; j++) begin
      tgap = 0;
      do begin
        @(posedge clk_in);
        #1 tgap++;
      end while (tick !== 1'b1 && tgap < 100);
      if (tgap >= 100) begin
        fail_count++;
        give_verdict();
      end
      @(posedge clk_in);
      #1;
    end
  endtask
  ////////////////////////////////////////
  initial begin
    logic [31:0] d;
    void'($urandom(32'hF15D4E93));
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    for (int i = 0; i < NUM_REGS; i++) exp_r[i] = dflt(i);
    chk_all();
    $display("test reset values done");
    for (int i = 0; i < NUM_REGS; i++) begin
      d = (i % 3 == 0) ? 32'h80000000 : (i % 3 == 1) ? 32'h7FFFFFFF : $urandom();
      wr(ofs[i], d);
      exp_r[i] = d;
    end
    chk_all();
    `CHK(thr.p1_pulse, {exp_r[18], 10'h000})
    `CHK(thr.p2_noload, {exp_r[21], 10'h000})
    `CHK(thr.p1_noload, {exp_r[19], 10'h000})
    `CHK(thr.p2_pulse, {exp_r[20], 10'h000})
    wr(OFS_CREEP_STATUS, 32'hFFFFFFFF);
    rd(OFS_CREEP_STATUS);
    `CHK(got, 32'h00000000)
    wr(16'h2001, $urandom());
    rd(16'h2001);
    `CHK(got, 32'h00000000)
    ce_in <= 1'b0;
    wr(OFS_P2_GAIN, ~exp_r[11]);
    ce_in <= 1'b1;
    chk_all();
    d = $urandom();
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= OFS_P1_GAIN;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 `CHK(rdata, d)
    $display("test register access done");
    wr(OFS_BPF_COEF, BPF_COEF_SLOW);
    slow <= 1'b1;
    rd(OFS_BPF_COEF);
    `CHK(got, BPF_COEF_SLOW)
    slow <= 1'b0;
    wr(OFS_BPF_COEF, RST_BPF_COEF);
    rd(OFS_BPF_COEF);
    `CHK(got, RST_BPF_COEF)
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    for (int i = 0; i < NUM_REGS; i++) exp_r[i] = dflt(i);
    chk_all();
    $display("test coefficient and second reset done");
    wr(OFS_P1_NOLOAD_THR, 32'h00000003);
    wr(OFS_P2_NOLOAD_THR, 32'h00000003);
    nl_en <= 1'b1;
    wait_tick(4);
    `CHK({cr1, cr2}, 2'h3)
    rd(OFS_CREEP_STATUS);
    `CHK(got, 32'h000000C0)
    // Negative power checks that the race uses magnitude
    pwr.p1_active <= -32'($urandom_range(60000, 3072));
    wait_tick(1);
    `CHK(cr1, 1'b0)
    rd(OFS_CREEP_STATUS);
    `CHK(got, 32'h00000040)
    pwr.p1_active <= 32'sh0;
    wr(OFS_P1_CONST_PWR, 32'h00001388);
    cpsel <= 1'b1;
    wait_tick(4);
    `CHK(cr1, 1'b0)
    cpsel <= 1'b0;
    // Residual energy from the negative and constant ticks drains one threshold per tick
    // before the anti-creep count can win; 26 ticks covers the largest random magnitude
    wait_tick(26);
    `CHK(cr1, 1'b1)
    pwr.p2_active <= 32'sh1388;
    dsel <= 1'b1;
    wait_tick(2);
    `CHK(cr2, 1'b0)
    dsel <= 1'b0;
    wait_tick(4);
    `CHK(cr2, 1'b1)
    wait_tick(2);
    `CHK(tgap, FT - 1)
    slow <= 1'b1;
    wait_tick(2);
    `CHK(tgap, ST - 1)
    slow <= 1'b0;
    nl_en <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1 `CHK({cr1, cr2}, 2'h0)
    $display("test no-load race done");
    give_verdict();
  end
endmodule
`default_nettype wire
